//--- design/wops_pkg.sv
package wops_pkg;

	// Waveform selection codes.
	typedef enum logic [2:0]
	{
		WOPS_WAVE_SINE,
		WOPS_WAVE_TRIANGLE,
		WOPS_WAVE_SQUARE,
		WOPS_WAVE_PULSE,
		WOPS_WAVE_RAMP,
		WOPS_WAVE_STAIR,
		WOPS_WAVE_ARB,
		WOPS_WAVE_NOISE
	} wops_wave_e;

	// Three-way option settings: automatic, forced low/on, forced high/off/trigger; low on the rear output acts as automatic.
	localparam logic [1:0] OPT_AUTO = 2'h0;
	localparam logic [1:0] OPT_LOW  = 2'h1;
	localparam logic [1:0] OPT_HIGH = 2'h2;

	// Rear output function codes.
	localparam logic [1:0] REAR_TRIG  = 2'h0;
	localparam logic [1:0] REAR_SWEEP = 2'h1;
	localparam logic [1:0] REAR_HOP   = 2'h2;

	// Frequency word is in hertz.
	localparam int          FREQ_W          = 32;
	localparam logic [31:0] CHANGEOVER_HZ   = 32'h0000_7530;
	localparam logic [31:0] FREQ_LIMIT_HZ   = 32'h0001_86a0;

	// Register byte offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_FREQ   = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_KEYS   = 8'h0c;

	// Control register field positions.
	localparam int CTRL_WAVE_LSB  = 0;
	localparam int CTRL_SQ_LSB    = 4;
	localparam int CTRL_FLT_LSB   = 6;
	localparam int CTRL_AUX_LSB   = 8;
	localparam int CTRL_REAR_LSB  = 10;
	localparam int CTRL_FREQUENCY_LIMIT_ENABLE_BIT = 12;
	localparam int CTRL_FSK_BIT   = 13;
	localparam int CTRL_HOP_BIT   = 14;
	localparam int CTRL_EDIT_BIT  = 15;
	localparam int CTRL_TMODE_BIT = 16;

	// Key register: writing one toggles sweep.
	localparam int KEY_SWEEP_BIT = 0;

	// Reset values.
	localparam logic [2:0]  RST_WAVE = 3'h0;
	localparam logic [31:0] RST_FREQ = 32'h0000_03e8;

	// Error display time and lamp flash half period.
	localparam int ERR_SHOW_MS   = 2000;
	localparam int FLASH_HALF_MS = 250;
	localparam int CLK_KHZ       = 200000;

endpackage

//--- design/wops_top.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module wops_top #(
	parameter int unsigned ERR_CYCLES   = wops_pkg::ERR_SHOW_MS * wops_pkg::CLK_KHZ,
	parameter int unsigned FLASH_CYCLES = wops_pkg::FLASH_HALF_MS * wops_pkg::CLK_KHZ
) (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        sweep_step_i,
	input  wire logic        sweep_active_i,
	input  wire logic        marker_i,
	input  wire logic        hop_signal_i,
	input  wire logic        trig_gen_i,
	input  wire logic        main_sync_i,
	output logic             square_comparator_o,
	output logic             filter_in_o,
	output logic             rc_filter_in_o,
	output logic             aux_comparator_o,
	output logic             aux_phase_apply_o,
	output logic             trig_sync_o,
	output logic             freq_step_o,
	output logic             error_o,
	output logic             sweep_on_o,
	output logic             sweep_lamp_o,
	output logic [1:0]       rear_function_o,
	output logic             rear_sync_output_o,
	output logic             rear_marker_o
);

	// Operator settings held in registers.
	logic [2:0]  wave_q;
	logic [1:0]  square_generation_select_q;
	logic [1:0]  filter_sel_q;
	logic [1:0]  aux_sel_q;
	logic [1:0]  rear_output_function_select_q;
	logic        frequency_limit_enable_q;
	logic        fsk_on_q;
	logic        hop_on_q;
	logic        edit_open_q;
	logic        trig_mode_q;
	logic [31:0] freq_q;
	logic        sweep_on_q;
	logic        sq_hold_q;
	logic        err_q;
	logic [31:0] err_cnt_q;
	logic [31:0] flash_cnt_q;
	logic        flash_q;
	logic        prev_freeze_q;

	// Bus decode.
	wire         acc_w    = psel_i & penable_i;
	wire         wr_w     = acc_w & pwrite_i;
	wire         hit_ctrl = paddr_i == wops_pkg::REG_CTRL;
	wire         hit_freq = paddr_i == wops_pkg::REG_FREQ;
	wire         hit_stat = paddr_i == wops_pkg::REG_STATUS;
	wire         hit_keys = paddr_i == wops_pkg::REG_KEYS;
	wire         mapped_w = hit_ctrl | hit_freq | hit_stat | hit_keys;
	wire [2:0]   new_wave = pwdata_i[wops_pkg::CTRL_WAVE_LSB +: 3];

	// Waveform classes.
	function automatic logic is_limited(input logic [2:0] w);
		is_limited = (w == wops_pkg::WOPS_WAVE_TRIANGLE) | (w == wops_pkg::WOPS_WAVE_RAMP)
			| (w == wops_pkg::WOPS_WAVE_STAIR) | (w == wops_pkg::WOPS_WAVE_ARB);
	endfunction

	function automatic logic is_sq(input logic [2:0] w);
		is_sq = (w == wops_pkg::WOPS_WAVE_SQUARE) | (w == wops_pkg::WOPS_WAVE_PULSE);
	endfunction

	function automatic logic is_classic(input logic [2:0] w);
		is_classic = is_sq(w) | (w == wops_pkg::WOPS_WAVE_SINE)
			| (w == wops_pkg::WOPS_WAVE_TRIANGLE);
	endfunction

	// Frequency stop checks on entry of a frequency or waveform.
	wire above_limit_new = pwdata_i > wops_pkg::FREQ_LIMIT_HZ;
	wire above_limit_cur = freq_q > wops_pkg::FREQ_LIMIT_HZ;
	wire err_freq  = wr_w & hit_freq & frequency_limit_enable_q
		& is_limited(wave_q) & above_limit_new;
	wire err_wave  = wr_w & hit_ctrl & pwdata_i[wops_pkg::CTRL_FREQUENCY_LIMIT_ENABLE_BIT]
		& is_limited(new_wave) & above_limit_cur;
	wire err_event = err_freq | err_wave;

	// Changeover above 30 kHz; exactly 30 kHz stays low.
	wire above_co   = freq_q > wops_pkg::CHANGEOVER_HZ;
	wire freeze_w   = sweep_on_q | fsk_on_q;
	wire sq_auto    = freeze_w ? sq_hold_q : above_co;
	wire square_hf  = (square_generation_select_q == wops_pkg::OPT_HIGH)
		| ((square_generation_select_q == wops_pkg::OPT_AUTO) & sq_auto);

	// Automatic filter choice and override.
	wire noise_w    = wave_q == wops_pkg::WOPS_WAVE_NOISE;
	wire flt_auto   = (wave_q == wops_pkg::WOPS_WAVE_SINE) | (wave_q == wops_pkg::WOPS_WAVE_TRIANGLE)
		| (is_sq(wave_q) & square_hf);
	wire flt_sel    = (filter_sel_q == wops_pkg::OPT_LOW) ? 1'b1 :
		(filter_sel_q == wops_pkg::OPT_HIGH) ? 1'b0 : flt_auto;
	wire filter_w   = flt_sel & ~noise_w;

	// Auxiliary output generation.
	wire aux_auto   = is_classic(wave_q) & above_co;
	wire aux_cmp    = (aux_sel_q == wops_pkg::OPT_HIGH)
		| ((aux_sel_q == wops_pkg::OPT_AUTO) & aux_auto);

	// Rear output function.
	wire [1:0] rear_auto = sweep_on_q ? wops_pkg::REAR_SWEEP :
		hop_on_q ? wops_pkg::REAR_HOP : wops_pkg::REAR_TRIG;
	wire [1:0] rear_fsel = (rear_output_function_select_q == wops_pkg::OPT_HIGH)
		? wops_pkg::REAR_TRIG : rear_auto;
	wire       rear_lvl  = (rear_fsel == wops_pkg::REAR_SWEEP) ? ~sweep_active_i :
		(rear_fsel == wops_pkg::REAR_HOP) ? hop_signal_i : trig_gen_i;

	wire [31:0] status_w = {20'h0_0000, flash_q, err_q, sweep_on_q, sq_hold_q,
		rear_fsel, aux_cmp, rc_filter_in_o, filter_w, square_hf, 2'h0};

	// Registered operator settings; rejected entries leave them unchanged.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wave_q                        <= wops_pkg::RST_WAVE;
			square_generation_select_q    <= wops_pkg::OPT_AUTO;
			filter_sel_q                  <= wops_pkg::OPT_AUTO;
			aux_sel_q                     <= wops_pkg::OPT_AUTO;
			rear_output_function_select_q <= wops_pkg::OPT_AUTO;
			frequency_limit_enable_q      <= 1'b0;
			fsk_on_q                      <= 1'b0;
			hop_on_q                      <= 1'b0;
			edit_open_q                   <= 1'b0;
			trig_mode_q                   <= 1'b0;
		end
		else if (wr_w & hit_ctrl & ~err_wave)
		begin
			wave_q                        <= new_wave;
			square_generation_select_q    <= pwdata_i[wops_pkg::CTRL_SQ_LSB +: 2];
			filter_sel_q                  <= pwdata_i[wops_pkg::CTRL_FLT_LSB +: 2];
			aux_sel_q                     <= pwdata_i[wops_pkg::CTRL_AUX_LSB +: 2];
			rear_output_function_select_q <= pwdata_i[wops_pkg::CTRL_REAR_LSB +: 2];
			frequency_limit_enable_q      <= pwdata_i[wops_pkg::CTRL_FREQUENCY_LIMIT_ENABLE_BIT];
			fsk_on_q                      <= pwdata_i[wops_pkg::CTRL_FSK_BIT];
			hop_on_q                      <= pwdata_i[wops_pkg::CTRL_HOP_BIT];
			edit_open_q                   <= pwdata_i[wops_pkg::CTRL_EDIT_BIT];
			trig_mode_q                   <= pwdata_i[wops_pkg::CTRL_TMODE_BIT];
		end
	end

	// Frequency entry, rejected when out of limit.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			freq_q <= wops_pkg::RST_FREQ;
		else if (wr_w & hit_freq & ~err_freq)
			freq_q <= pwdata_i;
	end

	// Sweep key toggles sweep; the square mode is captured as sweep or FSK starts.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sweep_on_q    <= 1'b0;
			sq_hold_q     <= 1'b0;
			prev_freeze_q <= 1'b0;
		end
		else
		begin
			if (wr_w & hit_keys & pwdata_i[wops_pkg::KEY_SWEEP_BIT])
				sweep_on_q <= ~sweep_on_q;
			prev_freeze_q <= freeze_w;
			if (~freeze_w)
				sq_hold_q <= above_co;
		end
	end

	// Error display timer; a new error restarts the two seconds.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			err_q     <= 1'b0;
			err_cnt_q <= 32'h0;
		end
		else if (err_event)
		begin
			err_q     <= 1'b1;
			err_cnt_q <= ERR_CYCLES - 1;
		end
		else if (err_cnt_q != 32'h0)
			err_cnt_q <= err_cnt_q - 32'h1;
		else
			err_q <= 1'b0;
	end

	// Lamp flash divider, running while the sweep edit menu is open.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			flash_cnt_q <= 32'h0;
			flash_q     <= 1'b0;
		end
		else if (~edit_open_q)
		begin
			flash_cnt_q <= 32'h0;
			flash_q     <= 1'b0;
		end
		else if (flash_cnt_q == FLASH_CYCLES - 1)
		begin
			flash_cnt_q <= 32'h0;
			flash_q     <= ~flash_q;
		end
		else
			flash_cnt_q <= flash_cnt_q + 32'h1;
	end

	// Path outputs registered for clean switching.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			square_comparator_o <= 1'b0;
			filter_in_o         <= 1'b1;
			rc_filter_in_o      <= 1'b0;
			aux_comparator_o    <= 1'b0;
			aux_phase_apply_o   <= 1'b1;
			trig_sync_o         <= 1'b0;
			freq_step_o         <= 1'b0;
			rear_function_o     <= wops_pkg::REAR_TRIG;
			rear_sync_output_o  <= 1'b0;
			rear_marker_o       <= 1'b0;
			prdata_o            <= 32'h0;
		end
		else
		begin
			square_comparator_o <= square_hf;
			filter_in_o         <= filter_w;
			rc_filter_in_o      <= noise_w;
			aux_comparator_o    <= aux_cmp;
			aux_phase_apply_o   <= ~aux_cmp;
			trig_sync_o         <= (trig_mode_q | fsk_on_q) ? main_sync_i : 1'b0;
			freq_step_o         <= sweep_on_q & sweep_step_i;
			rear_function_o     <= rear_fsel;
			rear_sync_output_o  <= rear_lvl;
			rear_marker_o       <= (rear_fsel == wops_pkg::REAR_SWEEP) & sweep_active_i
				& marker_i;
			if (psel_i & ~penable_i & ~pwrite_i)
				prdata_o <= hit_ctrl ? {15'h0, trig_mode_q, edit_open_q, hop_on_q, fsk_on_q,
					frequency_limit_enable_q, rear_output_function_select_q, aux_sel_q,
					filter_sel_q, square_generation_select_q, 1'b0, wave_q} :
					hit_freq ? freq_q : hit_stat ? status_w : 32'h0;
		end
	end

	// Bus answers in the first access cycle; unmapped addresses give an error.
	assign pready_o  = 1'b1;
	assign pslverr_o = acc_w & ~mapped_w;
	assign error_o   = err_q;
	assign sweep_on_o   = sweep_on_q;
	assign sweep_lamp_o = edit_open_q ? flash_q : sweep_on_q;

	// Checks next to the logic.
	sequence s_freq_rejected;
		err_freq ##1 err_q;
	endsequence

	chk_hold_reject: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		err_freq |=> (freq_q == $past(freq_q)) and err_q)
		else $error("Rejected frequency changed the setting.");
	chk_freq_error: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_freq_rejected |-> ##1 err_q)
		else $error("Error flag not held.");
	chk_noise_filter: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		noise_w |=> !filter_in_o && rc_filter_in_o)
		else $error("Noise path wrong.");
	chk_sweep_toggle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_w && hit_keys && pwdata_i[wops_pkg::KEY_SWEEP_BIT]
		|=> sweep_on_q != $past(sweep_on_q))
		else $error("Sweep key did not toggle.");
	chk_aux_phase: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		aux_comparator_o |-> !aux_phase_apply_o)
		else $error("Phase applied on comparator path.");
	chk_thirty_khz: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		freq_q == wops_pkg::CHANGEOVER_HZ && !freeze_w
		&& square_generation_select_q == wops_pkg::OPT_AUTO
		|=> !square_comparator_o)
		else $error("30 kHz switched to comparator.");
	chk_freeze_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		freeze_w && prev_freeze_q |-> $stable(sq_hold_q))
		else $error("Square mode changed during sweep.");
	chk_trig_force: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rear_output_function_select_q == wops_pkg::OPT_HIGH
		|=> rear_function_o == wops_pkg::REAR_TRIG)
		else $error("Forced trigger not on rear output.");
	chk_lamp_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!edit_open_q |-> sweep_lamp_o == sweep_on_q)
		else $error("Lamp does not follow sweep.");

	// One cycle after a setting stands: forced options beat the automatic choice, the RC filter is in only for noise, shaped waves keep a direct auto auxiliary.
	chk_filter_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		filter_sel_q == wops_pkg::OPT_LOW && !noise_w |=> filter_in_o)
		else $error("Forced-on filter is out.");
	chk_filter_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		filter_sel_q == wops_pkg::OPT_HIGH |=> !filter_in_o)
		else $error("Forced-off filter is in.");
	chk_rc_noise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!noise_w |=> !rc_filter_in_o)
		else $error("RC filter in without noise.");
	chk_sq_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		square_generation_select_q == wops_pkg::OPT_HIGH |=> square_comparator_o)
		else $error("Forced comparator square not selected.");
	chk_sq_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		square_generation_select_q == wops_pkg::OPT_LOW |=> !square_comparator_o)
		else $error("Forced digital square not selected.");
	chk_aux_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		aux_sel_q == wops_pkg::OPT_LOW |=> !aux_comparator_o)
		else $error("Forced direct auxiliary left.");
	chk_aux_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		aux_sel_q == wops_pkg::OPT_HIGH |=> aux_comparator_o)
		else $error("Forced comparator auxiliary left.");
	chk_aux_direct: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		aux_sel_q == wops_pkg::OPT_AUTO && !is_classic(wave_q)
		|=> !aux_comparator_o)
		else $error("Automatic auxiliary changed over for a shaped waveform.");

	// Entries: rejected ones keep the setting, accepted ones land.
	chk_wave_reject: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		err_wave |=> (wave_q == $past(wave_q)) and err_q)
		else $error("Rejected waveform changed the setting.");
	chk_limit_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_w && hit_freq && !frequency_limit_enable_q |=> freq_q == $past(pwdata_i))
		else $error("Frequency refused with the stop off.");

	// Sync, stepping and the rear output level.
	chk_sync_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!trig_mode_q && !fsk_on_q |=> !trig_sync_o)
		else $error("Trigger generator synchronized outside its modes.");
	chk_step_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!sweep_on_q |=> !freq_step_o)
		else $error("Frequency step without sweep.");
	chk_rear_sweep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rear_fsel == wops_pkg::REAR_SWEEP
		|=> rear_sync_output_o == !$past(sweep_active_i))
		else $error("Rear output not low during sweep.");
	chk_rear_hop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rear_fsel == wops_pkg::REAR_HOP |=> rear_sync_output_o == $past(hop_signal_i))
		else $error("Rear output not following hop.");
	chk_rear_trig: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		rear_output_function_select_q == wops_pkg::OPT_HIGH
		|=> rear_sync_output_o == $past(trig_gen_i))
		else $error("Rear output not following trigger generator.");

endmodule

`default_nettype wire

//--- test/wops_sweep_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far-side sweep engine and trigger sources, paced by a free counter.
module wops_sweep_model (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	input  wire logic sweep_on_i,
	output logic      step_o,
	output logic      active_o,
	output logic      marker_o,
	output logic      hop_o,
	output logic      trig_gen_o,
	output logic      sync_o
);
	logic [4:0] cnt_q;

	// The counter moves just after each rising edge.
	always_ff @(posedge clk_i or negedge rst_b_i)
		if (!rst_b_i)
			cnt_q <= 5'h0;
		else
			cnt_q <= cnt_q + 5'h1;

	// Steps strobe freely, so the selector must gate them with its own sweep state.
	assign step_o     = cnt_q[1:0] == 2'h3;
	assign active_o   = sweep_on_i & (cnt_q < 5'h1c);
	assign marker_o   = active_o & (cnt_q == 5'h0f);
	assign hop_o      = cnt_q[2];
	assign trig_gen_o = cnt_q[0] ^ cnt_q[3];
	assign sync_o     = cnt_q[1];
endmodule

`default_nettype wire

//--- test/wops_top_test.sv
`timescale 1ns/100ps
`default_nettype none

module wops_top_test;
	logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, rerr, l0;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, rd, f;
	logic [5:0]  pv;
	logic [31:0] rear_cw [4] = '{32'h1_0800, 32'h4000, 32'h2000, 32'h4400};
	wire  [31:0] prdata_o;
	wire  [3:0]  path;
	wire  [1:0]  rfn;
	wire         pready_o, pslverr_o, step, act, mark, hop, tgen, msync;
	wire         aux_ph, tsync, fstep, err, swp, lamp, rsync, rmark;
	int          n_fail, compares, n;

	// Selector under test with short error and flash counts.
	wops_top #(.ERR_CYCLES(20), .FLASH_CYCLES(4)) u_dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .sweep_step_i(step),
		.sweep_active_i(act), .marker_i(mark), .hop_signal_i(hop), .trig_gen_i(tgen),
		.main_sync_i(msync), .square_comparator_o(path[3]), .filter_in_o(path[2]),
		.rc_filter_in_o(path[1]), .aux_comparator_o(path[0]), .aux_phase_apply_o(aux_ph),
		.trig_sync_o(tsync), .freq_step_o(fstep), .error_o(err), .sweep_on_o(swp),
		.sweep_lamp_o(lamp), .rear_function_o(rfn), .rear_sync_output_o(rsync),
		.rear_marker_o(rmark)
	);

	// Sweep engine model follows the selector's sweep state.
	wops_sweep_model u_far (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .sweep_on_i(swp), .step_o(step), .active_o(act),
		.marker_o(mark), .hop_o(hop), .trig_gen_o(tgen), .sync_o(msync)
	);

	// Clock, and far-side levels as they stand at the coming rising edge.
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(negedge clk_i)
		pv <= {tgen, act, msync, step, mark, hop};

	// Expected square, filter, RC filter and auxiliary path for one setting.
	function automatic logic [3:0] exp_path(input logic [31:0] c, input logic [31:0] f);
		logic hi, s, fl, a;
		hi = f > wops_pkg::CHANGEOVER_HZ;
		s = c[5:4] == wops_pkg::OPT_HIGH;
		if (c[5:4] == wops_pkg::OPT_AUTO)
			s = hi;
		a = c[9:8] == wops_pkg::OPT_HIGH;
		if (c[9:8] == wops_pkg::OPT_AUTO)
			a = hi && c[2:0] <= 3'h3;
		fl = (c[2:0] <= 3'h1) || (c[2:0] <= 3'h3 && s);
		if (c[7:6] != wops_pkg::OPT_AUTO)
			fl = c[7:6] == wops_pkg::OPT_LOW;
		if (c[2:0] == 3'h7)
			fl = 1'b0;
		return {s, fl, c[2:0] == 3'h7, a};
	endfunction

	// Compare one value and count it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One bus transfer; ready, read data and error are taken at the edge ending the access.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= wr;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1);
		rd   = prdata_o;
		rerr = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Let a written setting reach the path outputs.
	task automatic wait_out();
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	// Program frequency and control, then check paths and the stored frequency.
	task automatic set_check(input logic [31:0] cw, input logic [31:0] fw);
		logic [3:0] e;
		apb(1'b1, wops_pkg::REG_FREQ, fw);
		apb(1'b1, wops_pkg::REG_CTRL, cw);
		wait_out();
		e = exp_path(cw, fw);
		chk(32'({path, aux_ph}), 32'({e, ~e[0]}));
		apb(1'b0, wops_pkg::REG_FREQ, 32'h0);
		chk(rd, fw);
	endtask

	// Watch the rear output and sync for a full model period: 0 trigger, 1 hop, 2 sweep.
	task automatic watch(input int m);
		logic [5:0] e;
		repeat (32)
		begin
			@(negedge clk_i);
			e = {wops_pkg::REAR_TRIG, pv[5], pv[3], 2'b00};
			if (m == 1)
				e = {wops_pkg::REAR_HOP, pv[0], 3'b000};
			if (m == 2)
				e = {wops_pkg::REAR_SWEEP, ~pv[4], 1'b0, pv[2], pv[1]};
			chk(32'({rfn, rsync, tsync, fstep, rmark}), 32'(e));
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic wrap_up();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Cut a hang short.
	initial
	begin
		#200000;
		n_fail++;
		wrap_up();
	end

	// Main sequence.
	initial
	begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		rst_b_i  = 1'b0;
		n_fail   = 0;
		compares = 0;
		void'($urandom(53586));
		repeat (7) @(posedge clk_i);
		@(negedge clk_i);
		chk(32'({path, aux_ph, err, swp, lamp, rfn, rsync}), 32'h240);
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		apb(1'b0, wops_pkg::REG_FREQ, 32'h0);
		chk(rd, wops_pkg::RST_FREQ);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], rerr}, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 54; i++)
		begin
			f = (i < 27) ? $urandom_range(30000, 1) : $urandom_range(200000, 30001);
			if (i % 27 == 0)
				f = wops_pkg::CHANGEOVER_HZ + 32'(i / 27);
			set_check({22'h0, 2'(i / 9 % 3), 2'(i / 3 % 3), 2'(i % 3), 1'b0, 3'($urandom)}, f);
		end
		$display("test paths done");
		set_check(32'h1001, 32'd100000);
		apb(1'b1, wops_pkg::REG_FREQ, 32'd150000);
		wait_out();
		chk(32'(err), 32'h1);
		repeat (12) @(negedge clk_i);
		chk(32'(err), 32'h1);
		repeat (12) @(negedge clk_i);
		chk(32'(err), 32'h0);
		apb(1'b1, wops_pkg::REG_CTRL, 32'h1000);
		set_check(32'h1000, 32'd150000);
		apb(1'b1, wops_pkg::REG_CTRL, 32'h1004);
		wait_out();
		apb(1'b0, wops_pkg::REG_CTRL, 32'h0);
		chk({rd[30:0], err}, 32'h2001);
		$display("test frequency stop done");
		set_check(32'h2, 32'd20000);
		apb(1'b1, wops_pkg::REG_KEYS, 32'h1);
		apb(1'b1, wops_pkg::REG_FREQ, 32'd50000);
		wait_out();
		chk(32'({swp, lamp, path[3]}), 32'h6);
		apb(1'b0, wops_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h260);
		watch(2);
		apb(1'b1, wops_pkg::REG_KEYS, 32'h1);
		wait_out();
		chk(32'({swp, lamp, path[3]}), 32'h1);
		apb(1'b1, wops_pkg::REG_CTRL, 32'h8000);
		wait_out();
		n = 0;
		repeat (16)
		begin
			l0 = lamp;
			@(negedge clk_i);
			n += (lamp !== l0);
		end
		chk(32'(n), 32'd4);
		$display("test sweep done");
		foreach (rear_cw[k])
		begin
			apb(1'b1, wops_pkg::REG_CTRL, rear_cw[k]);
			wait_out();
			watch(k % 2);
		end
		$display("test rear output done");
		wrap_up();
	end
endmodule

`default_nettype wire
